// ==== design/bits_rx_framer_status_irq.sv ====
// Receive framer status, latched alarm and interrupt register bank
`timescale 1ns/100ps
`default_nettype none
`include "rx_framer_status_params.svh"

module bits_rx_framer_status_irq
  import rx_framer_status_pkg::*;
#(
  parameter int SEARCH_CYCLES =
    `CRC4_SEARCH_TIME_MS * `CLK_FREQ_KHZ,
  parameter int DENSITY_N_MAX = `DENSITY_N_MAX,
  parameter int MAX_ZERO_RUN = `MAX_ZERO_RUN
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic out_of_frame,
  input wire logic loss_of_signal,
  input wire logic alarm_indication,
  input wire logic remote_alarm,
  input wire logic frame_align_search_active,
  input wire logic signaling_mf_search_active,
  input wire logic crc4_mf_search_active,
  input wire logic crc4_mf_sync_achieved,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic resync_alignment_changed,
  output logic interrupt_request_out
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int TIMER_W = $clog2(SEARCH_CYCLES + 1);
  localparam int HIST_W = `DENSITY_WIN_PER_N * (DENSITY_N_MAX + 1);
  localparam int FILL_W = $clog2(HIST_W + 1);
  localparam int ONES_W = $clog2(HIST_W + 1);
  localparam int ZRUN_W = $clog2(MAX_ZERO_RUN + 2);

  generate
    if (SEARCH_CYCLES < 1) begin : g_bad_timer
      $error("SEARCH_CYCLES must be at least 1");
    end
    if (DENSITY_N_MAX < 1 || MAX_ZERO_RUN < 1) begin : g_bad_density
      $error("density figures must be at least 1");
    end
    if (`SYNC_COUNT_WIDTH != 6) begin : g_bad_count
      $error("sync-search view needs a six-bit counter");
    end
    if (`DENSITY_WIN_PER_N < 1) begin : g_bad_window
      $error("density window step must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic wr_status;
  logic wr_enable;
  logic wr_event;
  logic wr_mode;
  logic wr_config;

  assign wr_status = wr_en && (addr == `OFS_ALARM_STATUS);
  assign wr_enable = wr_en && (addr == `OFS_ALARM_IRQ_EN);
  assign wr_event = wr_en && (addr == `OFS_DS1_EVENT);
  assign wr_mode = wr_en && (addr == `OFS_MASTER_MODE);
  assign wr_config = wr_en && (addr == `OFS_CONFIG_THREE);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic rx_e1_mode_select_r;
  logic rx_crc4_enable_r;
  reg_byte_type alarm_irq_en_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_e1_mode_select_r <= 1'b0;
    end else if (wr_mode) begin
      rx_e1_mode_select_r <= wr_data[`BIT_E1_MODE];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_crc4_enable_r <= 1'b0;
    end else if (wr_config) begin
      rx_crc4_enable_r <= wr_data[`BIT_CRC4_EN];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_irq_en_r <= `RST_BYTE;
    end else if (wr_enable) begin
      alarm_irq_en_r <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Real-time indicators and edge capture
  // ----------------------------------------------------------------
  logic [3:0] rt_now;
  logic [3:0] rt_prev_r;
  logic [3:0] rt_rise;
  logic [3:0] rt_fall;

  assign rt_now[ALM_OUT_OF_FRAME] = out_of_frame;
  assign rt_now[ALM_LOSS_OF_SIGNAL] = loss_of_signal;
  assign rt_now[ALM_ALARM_INDICATION] = alarm_indication;
  assign rt_now[ALM_REMOTE_ALARM] = remote_alarm;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rt_prev_r <= 4'h0;
    end else begin
      rt_prev_r <= rt_now;
    end
  end

  assign rt_rise = rt_now & ~rt_prev_r;
  assign rt_fall = ~rt_now & rt_prev_r;

  // ----------------------------------------------------------------
  // Latched alarm status
  // ----------------------------------------------------------------
  reg_byte_type alarm_status_r;
  reg_byte_type alarm_status_set;
  reg_byte_type alarm_status_clr;

  assign alarm_status_set = {rt_fall, rt_rise};
  assign alarm_status_clr = wr_status ? wr_data : `RST_BYTE;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_status_r <= `RST_BYTE;
    end else begin
      alarm_status_r <= (alarm_status_r & ~alarm_status_clr)
        | alarm_status_set;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request, alarm register only
  // ----------------------------------------------------------------
  logic alarm_pending;

  assign alarm_pending = |(alarm_status_r & alarm_irq_en_r);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_request_out <= 1'b0;
    end else begin
      interrupt_request_out <= alarm_pending;
    end
  end

  // ----------------------------------------------------------------
  // CRC-4 multiframe search timer and sync-search counter
  // ----------------------------------------------------------------
  localparam logic [TIMER_W-1:0] TIMER_LAST =
    TIMER_W'(SEARCH_CYCLES - 1);

  logic [TIMER_W-1:0] search_timer_r;
  logic search_running;
  logic search_expired;
  logic [`SYNC_COUNT_WIDTH-1:0] crc4_search_counter_r;
  logic counter_clear;

  assign search_running = rx_e1_mode_select_r && rx_crc4_enable_r
    && crc4_mf_search_active && !crc4_mf_sync_achieved;
  assign search_expired = search_running
    && (search_timer_r == TIMER_LAST);
  assign counter_clear = crc4_mf_sync_achieved
    || !rx_crc4_enable_r
    || (wr_config && !wr_data[`BIT_CRC4_EN]);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      search_timer_r <= '0;
    end else if (!search_running || search_expired) begin
      search_timer_r <= '0;
    end else begin
      search_timer_r <= search_timer_r + TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crc4_search_counter_r <= '0;
    end else if (counter_clear) begin
      crc4_search_counter_r <= '0;
    end else if (search_expired) begin
      // Natural wrap of the six-bit count
      crc4_search_counter_r <= crc4_search_counter_r
        + `SYNC_COUNT_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // Pulse density monitor
  // ----------------------------------------------------------------
  logic [HIST_W-1:0] hist_r;
  logic [FILL_W-1:0] fill_r;
  logic [FILL_W-1:0] fill_nxt;
  logic [ZRUN_W-1:0] zero_run_r;
  logic [ZRUN_W-1:0] zero_run_nxt;
  logic [DENSITY_N_MAX:1] window_viol;
  logic density_viol;

  assign fill_nxt = (fill_r == FILL_W'(HIST_W)) ? fill_r
    : fill_r + FILL_W'(1);
  assign zero_run_nxt = rx_bit ? '0
    : (zero_run_r == ZRUN_W'(MAX_ZERO_RUN + 1)) ? zero_run_r
    : zero_run_r + ZRUN_W'(1);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hist_r <= '0;
      fill_r <= '0;
      zero_run_r <= '0;
    end else if (rx_bit_valid) begin
      hist_r <= {hist_r[HIST_W-2:0], rx_bit};
      fill_r <= fill_nxt;
      zero_run_r <= zero_run_nxt;
    end
  end

  // One running ones count per window length
  genvar n;
  generate
    for (n = 1; n <= DENSITY_N_MAX; n++) begin : g_win
      localparam int WIN = `DENSITY_WIN_PER_N * (n + 1);
      logic [ONES_W-1:0] ones_r;
      logic [ONES_W-1:0] ones_nxt;

      assign ones_nxt = ones_r + ONES_W'(rx_bit)
        - ONES_W'(hist_r[WIN-1]);
      assign window_viol[n] = rx_bit_valid
        && (fill_nxt >= FILL_W'(WIN))
        && (ones_nxt < ONES_W'(n));

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          ones_r <= '0;
        end else if (rx_bit_valid) begin
          ones_r <= ones_nxt;
        end
      end
    end
  endgenerate

  assign density_viol = (|window_viol) || (rx_bit_valid
    && zero_run_nxt > ZRUN_W'(MAX_ZERO_RUN));

  // ----------------------------------------------------------------
  // DS1 latched events, never routed to the interrupt
  // ----------------------------------------------------------------
  logic rx_density_violation_r;
  logic alignment_changed_event_r;
  logic ds1_mode;
  logic event_clr_density;
  logic event_clr_align;

  assign ds1_mode = !rx_e1_mode_select_r;
  assign event_clr_density = wr_event && wr_data[`BIT_DENSITY_VIOL];
  assign event_clr_align = wr_event && wr_data[`BIT_ALIGN_CHANGED];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_density_violation_r <= 1'b0;
    end else if (ds1_mode && density_viol) begin
      rx_density_violation_r <= 1'b1;
    end else if (event_clr_density) begin
      rx_density_violation_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alignment_changed_event_r <= 1'b0;
    end else if (ds1_mode && resync_alignment_changed) begin
      alignment_changed_event_r <= 1'b1;
    end else if (event_clr_align) begin
      alignment_changed_event_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data assembly
  // ----------------------------------------------------------------
  reg_byte_type e1_sync_view;
  reg_byte_type ds1_event_view;
  reg_byte_type rd_data_nxt;

  always_comb begin
    e1_sync_view = `RST_BYTE;
    if (rx_e1_mode_select_r) begin
      e1_sync_view[7:3] = {crc4_search_counter_r[5:2],
        crc4_search_counter_r[0]};
      e1_sync_view[`BIT_FAS_SEARCH] = frame_align_search_active;
      e1_sync_view[`BIT_CAS_SEARCH] = signaling_mf_search_active;
      e1_sync_view[`BIT_CRC4_SEARCH] = crc4_mf_search_active;
    end
  end

  always_comb begin
    ds1_event_view = `RST_BYTE;
    if (ds1_mode) begin
      ds1_event_view[`BIT_DENSITY_VIOL] = rx_density_violation_r;
      ds1_event_view[`BIT_ALIGN_CHANGED] = alignment_changed_event_r;
    end
  end

  always_comb begin
    rd_data_nxt = `RST_BYTE;
    if (rd_en) begin
      unique case (addr)
        `OFS_IRQ_INFO: rd_data_nxt[`BIT_IRQ_INFO_ALARM] =
          alarm_pending;
        `OFS_RT_ALARM_INFO: rd_data_nxt[3:0] = rt_prev_r;
        `OFS_E1_SYNC_INFO: rd_data_nxt = e1_sync_view;
        `OFS_ALARM_STATUS: rd_data_nxt = alarm_status_r;
        `OFS_ALARM_IRQ_EN: rd_data_nxt = alarm_irq_en_r;
        `OFS_DS1_EVENT: rd_data_nxt = ds1_event_view;
        `OFS_MASTER_MODE: rd_data_nxt[`BIT_E1_MODE] =
          rx_e1_mode_select_r;
        `OFS_CONFIG_THREE: rd_data_nxt[`BIT_CRC4_EN] =
          rx_crc4_enable_r;
        default: rd_data_nxt = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `RST_BYTE;
    end else begin
      rd_data <= rd_data_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== design/rx_framer_status_params.svh ====
// Offsets, field positions, reset values and timing for the status bank
`ifndef RX_FRAMER_STATUS_PARAMS_SVH
`define RX_FRAMER_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_IRQ_INFO 8'h30
`define OFS_RT_ALARM_INFO 8'h31
`define OFS_E1_SYNC_INFO 8'h32
`define OFS_ALARM_STATUS 8'h33
`define OFS_ALARM_IRQ_EN 8'h34
`define OFS_DS1_EVENT 8'h35
`define OFS_MASTER_MODE 8'h3e
`define OFS_CONFIG_THREE 8'h3f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_IRQ_INFO_ALARM 0
`define BIT_E1_MODE 0
`define BIT_CRC4_EN 0
`define BIT_FAS_SEARCH 2
`define BIT_CAS_SEARCH 1
`define BIT_CRC4_SEARCH 0
`define BIT_DENSITY_VIOL 7
`define BIT_ALIGN_CHANGED 5
`define ALARM_CLEARED_LSB 4
`define ALARM_SET_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00

// ----------------------------------------------------------------
// Timing and density figures
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ 50000
`define CRC4_SEARCH_TIME_MS 8
`define MAX_ZERO_RUN 15
`define DENSITY_N_MAX 23
`define DENSITY_WIN_PER_N 8
`define SYNC_COUNT_WIDTH 6

`endif

// ==== design/rx_framer_status_pkg.sv ====
// Types shared by the receive framer status bank
package rx_framer_status_pkg;

  typedef logic [7:0] reg_byte_type;

  // Alarm indicator positions within a nibble
  typedef enum logic [1:0] {
    ALM_OUT_OF_FRAME,
    ALM_LOSS_OF_SIGNAL,
    ALM_ALARM_INDICATION,
    ALM_REMOTE_ALARM
  } alarm_idx_type;

endpackage

// ==== testbench/bits_rx_framer_status_irq_bench.sv ====
// Self-checking bench for the receive status bank
`timescale 1ns/100ps
`default_nettype none
`include "rx_framer_status_params.svh"
module bits_rx_framer_status_irq_bench
  import rx_framer_status_pkg::*;
;
  localparam reg_byte_type II = `OFS_IRQ_INFO;
  localparam reg_byte_type RT = `OFS_RT_ALARM_INFO;
  localparam reg_byte_type SY = `OFS_E1_SYNC_INFO;
  localparam reg_byte_type AS = `OFS_ALARM_STATUS;
  localparam reg_byte_type EN = `OFS_ALARM_IRQ_EN;
  localparam reg_byte_type DS = `OFS_DS1_EVENT;
  localparam reg_byte_type MM = `OFS_MASTER_MODE;
  localparam reg_byte_type C3 = `OFS_CONFIG_THREE;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  reg_byte_type addr = 8'h00;
  reg_byte_type wr_data = 8'h00;
  reg_byte_type rd_data;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_seen = 1'b0;
  logic irq;
  logic irq_look = 1'b0;
  logic irq_q[$];
  logic [3:0] ind = 4'h0;
  logic [2:0] srch = 3'h0;
  logic sync_ok = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_vld = 1'b0;
  logic align_chg = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_f8a9;
  reg_byte_type exp_q[$];
  always #10 clk_sys = ~clk_sys;
  bits_rx_framer_status_irq #(.SEARCH_CYCLES(20))
    bits_rx_framer_status_irq_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .out_of_frame(ind[0]), .loss_of_signal(ind[1]),
    .alarm_indication(ind[2]), .remote_alarm(ind[3]),
    .frame_align_search_active(srch[2]),
    .signaling_mf_search_active(srch[1]),
    .crc4_mf_search_active(srch[0]), .crc4_mf_sync_achieved(sync_ok),
    .rx_bit(rx_bit), .rx_bit_valid(rx_vld),
    .resync_alignment_changed(align_chg), .interrupt_request_out(irq)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input reg_byte_type got, input reg_byte_type exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input reg_byte_type a, input reg_byte_type d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input reg_byte_type a, input reg_byte_type e);
    exp_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk_irq(input logic e);
    irq_q.push_back(e);
    irq_look <= 1'b1;
    @(posedge clk_sys);
    irq_look <= 1'b0;
  endtask
  task automatic pulse_align;
    align_chg <= 1'b1;
    @(posedge clk_sys);
    align_chg <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic bits(input int n);
    repeat (n) begin
      rx_vld <= 1'b1;
      @(posedge clk_sys);
      rx_vld <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // Hold a failing search for n periods, then read the counter
  task automatic run(input int n, input reg_byte_type e);
    seed = xs(seed);
    srch <= {seed[1:0], 1'b1};
    idle(20 * n + 10);
    srch[0] <= 1'b0;
    @(posedge clk_sys);
    rd(SY, e | {5'h00, srch[2:1], 1'b0});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) rd_seen <= rd_en;
  always @(negedge clk_sys) begin
    if (rd_seen) cmp(rd_data, exp_q.pop_front());
    if (irq_look) cmp({7'h00, irq}, {7'h00, irq_q.pop_front()});
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    wr(8'h40, 8'hff);
    for (int a = 8'h30; a < 8'h41; a++) rd(8'(a), 8'h00);
    seed = xs(seed);
    wr(EN, seed[7:0]);
    rd(EN, seed[7:0]);
    wr(EN, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ind[i] <= 1'b1;
      idle(2);
      rd(RT, 8'h01 << i);
      rd(AS, 8'h01 << i);
      ind[i] <= 1'b0;
      idle(2);
      rd(RT, 8'h00);
      rd(AS, 8'h11 << i);
      wr(AS, 8'h00);
      rd(AS, 8'h11 << i);
      wr(AS, 8'h01 << i);
      rd(AS, 8'h10 << i);
      wr(AS, 8'hff);
      rd(AS, 8'h00);
    end
    ind[0] <= 1'b1;
    wr(AS, 8'h01);
    rd(AS, 8'h01);
    rd(II, 8'h00);
    wr(EN, 8'hfe);
    chk_irq(1'b0);
    wr(EN, 8'h01);
    chk_irq(1'b1);
    rd(II, 8'h01);
    wr(AS, 8'h01);
    chk_irq(1'b0);
    ind[0] <= 1'b0;
    idle(2);
    chk_irq(1'b0);
    rd(AS, 8'h10);
    wr(AS, 8'hff);
    wr(MM, 8'h01);
    wr(C3, 8'h01);
    rd(C3, 8'h01);
    run(5, 8'h18);
    run(59, 8'h00);
    run(3, 8'h08);
    sync_ok <= 1'b1;
    run(0, 8'h00);
    sync_ok <= 1'b0;
    run(5, 8'h18);
    srch[0] <= 1'b1;
    wr(C3, 8'h00);
    rd(SY, {5'h00, srch});
    wr(C3, 8'h01);
    rd(SY, {5'h00, srch});
    pulse_align();
    rd(DS, 8'h00);
    wr(MM, 8'h00);
    rd(SY, 8'h00);
    rx_bit <= 1'b1;
    bits(200);
    rd(DS, 8'h00);
    rx_bit <= 1'b0;
    bits(15);
    rd(DS, 8'h00);
    bits(1);
    rd(DS, 8'h80);
    pulse_align();
    rd(DS, 8'ha0);
    wr(EN, 8'hff);
    chk_irq(1'b0);
    wr(DS, 8'h80);
    rd(DS, 8'h20);
    wr(DS, 8'hff);
    rd(DS, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== testbench/rx_status_chk_sva.sv ====
// Assertion checker for the receive status bank
`timescale 1ns/100ps
`default_nettype none
module rx_status_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic out_of_frame,
  input wire logic loss_of_signal,
  input wire logic alarm_indication,
  input wire logic remote_alarm,
  input wire logic frame_align_search_active,
  input wire logic signaling_mf_search_active,
  input wire logic crc4_mf_search_active,
  input wire logic interrupt_request_out
);
  wire logic [3:0] ind = {remote_alarm, alarm_indication,
    loss_of_signal, out_of_frame};
  wire logic [2:0] srch = {frame_align_search_active,
    signaling_mf_search_active, crc4_mf_search_active};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not idle");
  rt_info_a: assert property ($past(rd_en) && $past(addr) == 8'h31 &&
    $past(ind) == $past(ind, 2) |-> rd_data == {4'h0, $past(ind)})
    else $error("real-time info mismatch");
  irq_cause_a: assert property ($rose(interrupt_request_out) |->
    $past(ind, 2) != $past(ind, 3) ||
    ($past(wr_en, 2) && $past(addr, 2) == 8'h34))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(interrupt_request_out) |->
    $past(wr_en, 2) && $past(addr, 2) inside {8'h33, 8'h34})
    else $error("interrupt fell without write");
  unmap_rd_a: assert property ($past(rd_en) &&
    !($past(addr) inside {[8'h30:8'h35], 8'h3e, 8'h3f}) |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  irq_info_a: assert property ($past(rd_en) && $past(addr) == 8'h30 |->
    rd_data == {7'h00, interrupt_request_out})
    else $error("interrupt info mismatch");
  e1_info_a: assert property ($past(rd_en) && $past(addr) == 8'h32 &&
    $past(srch) == $past(srch, 2) |->
    rd_data[2:0] == 3'b000 || rd_data[2:0] == $past(srch))
    else $error("search flags mismatch");
  ds1_resvd_a: assert property ($past(rd_en) && $past(addr) == 8'h35 |->
    rd_data[6] == 1'b0 && rd_data[4:0] == 5'h00)
    else $error("event register spare bits set");
  cover property ($rose(interrupt_request_out));
  cover property (wr_en && addr == 8'h33);
  cover property (rd_en && addr == 8'h32);
endmodule
bind bits_rx_framer_status_irq rx_status_chk rx_status_chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .out_of_frame(out_of_frame),
  .loss_of_signal(loss_of_signal), .alarm_indication(alarm_indication),
  .remote_alarm(remote_alarm),
  .frame_align_search_active(frame_align_search_active),
  .signaling_mf_search_active(signaling_mf_search_active),
  .crc4_mf_search_active(crc4_mf_search_active),
  .interrupt_request_out(interrupt_request_out)
);
`default_nettype wire
